// ---- rtl/pfhbp_port.sv ----
// Host bus port of a 16-bit parallel flash: pins, command interface, automation, burst.
module pfhbp_port
    import pfhbp_pkg::*;
#(
    parameter int AW = 16, // word address bits, the top one is the die select bit
    parameter int BLK_BITS = 4, // block index bits at the top of the address, the die select bit included
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h005a // arbitrary value
) (
    input wire logic clk, // internal clock
    input wire logic arst_n, // asynchronous reset
    input wire logic linkClk, // host burst clock
    input wire logic chipSelN, // chip select pin
    input wire logic outEnN, // output enable pin
    input wire logic writeEnN, // write strobe pin
    input wire logic addressValidN, // address valid pin
    input wire logic writeProtN, // write protect pin
    input wire logic resetPinN, // reset pin
    input wire logic [AW-1:0] addr, // word address pins
    input wire logic [15:0] dqIn, // data bus, pin level
    output logic [15:0] dqOut, // asynchronous read data
    output logic dqOe, // asynchronous read data enable
    output logic [15:0] syncDqOut, // burst read data
    output logic syncDqOe, // burst read data enable
    output logic waitOut, // wait level
    output logic waitOe, // wait enable
    output logic [1:0] dieSel // one-hot die selected: bit 1 upper, bit 0 lower
);

    localparam int NBLK = 2 ** BLK_BITS;
    localparam int BW = AW - BLK_BITS;

    if (AW < 16 || AW > 24 || BLK_BITS < 1 || BLK_BITS > 8) begin : g_chk
        $error("pfhbp_port: AW must be 16..24 and BLK_BITS 1..8");
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers on the internal clock.

    logic [5:0] pinMeta;
    logic [5:0] pinSync;
    logic [AW-1:0] addrMeta;
    logic [AW-1:0] addrSync;
    logic [15:0] dqMeta;
    logic [15:0] dqSync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta <= PIN_IDLE;
            pinSync <= PIN_IDLE;
            addrMeta <= '0;
            addrSync <= '0;
            dqMeta <= 16'h0000;
            dqSync <= 16'h0000;
        end else begin
            pinMeta <= {chipSelN, writeEnN, outEnN, addressValidN, writeProtN, resetPinN};
            pinSync <= pinMeta;
            addrMeta <= addr;
            addrSync <= addrMeta;
            dqMeta <= dqIn;
            dqSync <= dqMeta;
        end
    end

    logic ceS, weS, oeS, advS, wpS, rstS;
    assign {ceS, weS, oeS, advS, wpS, rstS} = pinSync;

    ////////////////////////////////////////////////////////////////////////////////////
    // Write cycle capture and address latch.

    logic wrActive;
    logic wrPrev;
    logic wrEnd;
    logic [AW-1:0] wrAddr;
    logic [15:0] wrData;
    logic [AW-1:0] latAddr;

    assign wrActive = !ceS && !weS && oeS && rstS;
    assign wrEnd = wrPrev && !wrActive && rstS;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPrev <= 1'b0;
            wrAddr <= '0;
            wrData <= 16'h0000;
        end else begin
            wrPrev <= wrActive;
            if (wrActive) begin
                wrAddr <= addrSync;
                wrData <= dqSync;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latAddr <= '0;
        end else if (!advS) begin
            latAddr <= addrSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Command interface and program/erase automation.

    pfhbp_state_t state;
    pfhbp_rmode_t readMode;
    logic [7:0] pend;
    logic [7:0] cmd;
    logic first, second;
    logic [BLK_BITS-1:0] wrBlk;
    logic blkProt;
    logic progErr, eraseErr, lockErr;
    logic [15:0] progTmr, eraseTmr;
    logic [AW-1:0] progAddr;
    logic [15:0] progData;
    logic [BLK_BITS-1:0] eraseBlk;
    logic [BW-1:0] eraseIdx;
    logic [NBLK-1:0] locked, lockDown;
    logic [15:0] read_config_reg;
    logic [7:0] status;

    assign cmd = wrData[7:0];
    assign first = wrEnd && pend == CMD_NONE;
    assign second = wrEnd && pend != CMD_NONE;
    assign wrBlk = wrAddr[AW-1 -: BLK_BITS];
    assign blkProt = locked[wrBlk];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            readMode <= RM_ARRAY;
            pend <= CMD_NONE;
            {progErr, eraseErr, lockErr} <= 3'h0;
            progTmr <= 16'h0000;
            eraseTmr <= 16'h0000;
            progAddr <= '0;
            progData <= 16'h0000;
            eraseBlk <= '0;
            eraseIdx <= '0;
        end else if (!rstS) begin
            state <= ST_IDLE;
            readMode <= RM_ARRAY;
            pend <= CMD_NONE;
            {progErr, eraseErr, lockErr} <= 3'h0;
        end else begin
            unique case (state)
                ST_PROG, ST_SUSP_PROG: begin
                    if (progTmr != 16'h0000) begin
                        progTmr <= progTmr - 16'h0001;
                    end else begin
                        state <= (state == ST_PROG) ? ST_IDLE : ST_ERASE_SUSP;
                    end
                end
                ST_ERASE: begin
                    if (eraseTmr != 16'h0000) begin
                        eraseTmr <= eraseTmr - 16'h0001;
                    end else if (eraseIdx == '1) begin
                        state <= ST_IDLE;
                    end else begin
                        eraseIdx <= eraseIdx + 1'b1;
                    end
                end
                default: begin
                end
            endcase
            if (first) begin
                case (cmd)
                    CMD_READ_ARRAY: readMode <= RM_ARRAY;
                    CMD_READ_STATUS: readMode <= RM_STATUS;
                    CMD_READ_ID: readMode <= RM_ID;
                    CMD_CLEAR_STATUS: {progErr, eraseErr, lockErr} <= 3'h0;
                    CMD_PROGRAM, CMD_ERASE, CMD_LOCK_SETUP: pend <= cmd;
                    CMD_SUSPEND: begin
                        readMode <= RM_STATUS;
                        if (state == ST_PROG) begin
                            state <= ST_PROG_SUSP;
                        end else if (state == ST_ERASE) begin
                            state <= ST_ERASE_SUSP;
                        end
                    end
                    CMD_CONFIRM: begin
                        readMode <= RM_STATUS;
                        if (state == ST_PROG_SUSP) begin
                            state <= ST_PROG;
                        end else if (state == ST_ERASE_SUSP) begin
                            state <= ST_ERASE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (second) begin
                pend <= CMD_NONE;
                if (pend == CMD_PROGRAM) begin
                    readMode <= RM_STATUS;
                    if (blkProt || !(state == ST_IDLE || state == ST_ERASE_SUSP)
                            || (state == ST_ERASE_SUSP && wrBlk == eraseBlk)) begin
                        progErr <= 1'b1;
                        lockErr <= lockErr | blkProt;
                    end else begin
                        progAddr <= wrAddr;
                        progData <= wrData;
                        progTmr <= PROG_CYCLES;
                        state <= (state == ST_IDLE) ? ST_PROG : ST_SUSP_PROG;
                    end
                end else if (pend == CMD_ERASE) begin
                    readMode <= RM_STATUS;
                    if (cmd != CMD_CONFIRM || blkProt || state != ST_IDLE) begin
                        eraseErr <= 1'b1;
                        lockErr <= lockErr | blkProt;
                    end else begin
                        eraseBlk <= wrBlk;
                        eraseIdx <= '0;
                        eraseTmr <= ERASE_CYCLES;
                        state <= ST_ERASE;
                    end
                end
            end
        end
    end

    // lock state applies on the confirming cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            locked <= '1;
            lockDown <= '0;
            read_config_reg <= RCR_RESET;
        end else if (!rstS) begin
            locked <= '1;
            lockDown <= '0;
            read_config_reg <= RCR_RESET;
        end else if (second && pend == CMD_LOCK_SETUP) begin
            case (cmd)
                CMD_LOCK: locked[wrBlk] <= 1'b1;
                CMD_LOCKDOWN: begin
                    locked[wrBlk] <= 1'b1;
                    lockDown[wrBlk] <= 1'b1;
                end
                CMD_CONFIRM: if (!(lockDown[wrBlk] && !wpS)) locked[wrBlk] <= 1'b0;
                // configuration value rides on the address bus
                CMD_SET_CONFIG: read_config_reg <= wrAddr[15:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        status = 8'h00;
        status[SR_READY] = !(state == ST_PROG || state == ST_ERASE || state == ST_SUSP_PROG);
        status[SR_ERASE_SUSP] = state == ST_ERASE_SUSP || state == ST_SUSP_PROG;
        status[SR_ERASE_ERR] = eraseErr;
        status[SR_PROG_ERR] = progErr;
        status[SR_PROG_SUSP] = state == ST_PROG_SUSP;
        status[SR_LOCK_ERR] = lockErr;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Array storage.

    logic [15:0] mem [0:(2**AW)-1];
    logic memWe;
    logic [AW-1:0] memAddr;
    logic [15:0] memData;

    always_comb begin
        memWe = 1'b0;
        memAddr = progAddr;
        memData = progData;
        if ((state == ST_PROG || state == ST_SUSP_PROG) && progTmr == 16'h0000) begin
            memWe = rstS;
        end else if (state == ST_ERASE && eraseTmr == 16'h0000) begin
            memWe = rstS;
            memAddr = {eraseBlk, eraseIdx};
            memData = ERASED_WORD;
        end
    end

    // No reset: the array keeps its contents as a flash would.
    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[memAddr] <= memData;
        end
    end

    function automatic logic [15:0] readWord(input pfhbp_rmode_t m, input logic [AW-1:0] a);
        logic [15:0] w;
        w = mem[a];
        if (m == RM_STATUS) begin
            w = {8'h00, status};
        end else if (m == RM_ID) begin
            unique case (a[1:0])
                ID_MAKER: w = MAKER_CODE;
                ID_DEVICE: w = DEVICE_CODE;
                ID_LOCK: w = {14'h0000, lockDown[a[AW-1 -: BLK_BITS]], locked[a[AW-1 -: BLK_BITS]]};
                ID_CONFIG: w = read_config_reg;
            endcase
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // Asynchronous read outputs on the internal clock.

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dqOut <= 16'h0000;
            dqOe <= 1'b0;
            waitOe <= 1'b0;
            dieSel <= 2'h0;
        end else begin
            dqOut <= readWord(readMode, latAddr);
            // drive only in asynchronous mode while selected
            dqOe <= !ceS && !oeS && weS && rstS && read_config_reg[RCR_ASYNC_BIT];
            waitOe <= !ceS && !oeS && rstS;
            // top address bit picks the die
            dieSel <= ceS ? 2'h0 : (latAddr[AW-1] ? 2'h2 : 2'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Burst read handshake, internal side.

    logic reqMeta, reqSync, reqSeen, ackT;
    logic [15:0] rspData;
    logic [AW-1:0] linkAddr;
    logic reqT;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
            reqSeen <= 1'b0;
            ackT <= 1'b0;
            rspData <= 16'h0000;
        end else begin
            reqMeta <= reqT;
            reqSync <= reqMeta;
            if (reqSync != reqSeen) begin
                reqSeen <= reqSync;
                rspData <= readWord(readMode, linkAddr);
                ackT <= ~ackT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Burst read, host clock side.

    logic [1:0] cfgMeta, cfgSync;
    logic [1:0] ctlMeta, ctlSync;
    logic ackMeta, ackSync, ackSeen;
    logic syncMode, waitPol, ceL, oeL, pending, arrive;

    assign {syncMode, waitPol} = cfgSync;
    assign {ceL, oeL} = ctlSync;
    assign pending = reqT != ackSeen;
    assign arrive = ackSync != ackSeen;

    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            cfgMeta <= 2'h0;
            cfgSync <= 2'h0;
            ctlMeta <= 2'h3;
            ctlSync <= 2'h3;
            ackMeta <= 1'b0;
            ackSync <= 1'b0;
            ackSeen <= 1'b0;
            reqT <= 1'b0;
            linkAddr <= '0;
            syncDqOut <= 16'h0000;
            waitOut <= 1'b0;
        end else begin
            cfgMeta <= {!read_config_reg[RCR_ASYNC_BIT], read_config_reg[RCR_WAIT_POL_BIT]};
            cfgSync <= cfgMeta;
            ctlMeta <= {chipSelN, outEnN};
            ctlSync <= ctlMeta;
            ackMeta <= ackT;
            ackSync <= ackMeta;
            if (arrive) begin
                ackSeen <= ackSync;
                // data launched on the host clock
                syncDqOut <= rspData;
                if (!ceL) begin
                    linkAddr <= linkAddr + 1'b1;
                    reqT <= ~reqT;
                end
            end else if (syncMode && !ceL && !addressValidN && !pending) begin
                // capture at the clock edge with address valid low
                linkAddr <= addr;
                reqT <= ~reqT;
            end
            waitOut <= (syncMode && !ceL && !oeL && !arrive) ? waitPol : !waitPol;
        end
    end

    // Chip select clears the burst drive directly: the host clock may stop once deselected.
    always_ff @(posedge linkClk or negedge arst_n or posedge chipSelN) begin
        if (!arst_n || chipSelN) begin
            syncDqOe <= 1'b0;
        end else begin
            syncDqOe <= syncMode && !oeL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    rstReject_a: assert property (@(posedge clk) disable iff (!arst_n)
        !rstS |=> pend == CMD_NONE && !wrPrev) else $error("write in reset");
    resetMode_a: assert property (@(posedge clk) disable iff (!arst_n)
        !rstS |=> read_config_reg == RCR_RESET && readMode == RM_ARRAY && state == ST_IDLE)
        else $error("reset pin did not restore async array read");
    floatOut_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ceS || oeS) |=> !dqOe && !waitOe) else $error("outputs driven while deselected");
    lockRefuse_a: assert property (@(posedge clk) disable iff (!arst_n)
        (second && pend == CMD_PROGRAM && blkProt && state == ST_IDLE)
        |=> progErr && lockErr && state == ST_IDLE) else $error("locked block programmed");
    lockNow_a: assert property (@(posedge clk) disable iff (!arst_n)
        (second && pend == CMD_LOCK_SETUP && cmd == CMD_LOCK && rstS)
        |=> locked[$past(wrBlk)]) else $error("lock not immediate");
    lockDown_a: assert property (@(posedge clk) disable iff (!arst_n)
        (second && pend == CMD_LOCK_SETUP && cmd == CMD_CONFIRM && rstS
        && lockDown[wrBlk] && !wpS) |=> locked[$past(wrBlk)]) else $error("lock-down unlocked");
    eraseSusp_a: assert property (@(posedge clk) disable iff (!arst_n)
        (first && cmd == CMD_SUSPEND && state == ST_ERASE && rstS)
        |=> state == ST_ERASE_SUSP && status[SR_ERASE_SUSP] && status[SR_READY])
        else $error("erase not suspended");
    progEnd_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == ST_PROG && progTmr == 16'h0000 && rstS && !first)
        |=> state == ST_IDLE && status[SR_READY]) else $error("program did not finish");
    eraseBlk_a: assert property (@(posedge clk) disable iff (!arst_n)
        memWe && state == ST_ERASE |-> memAddr[AW-1 -: BLK_BITS] == eraseBlk
        && memData == ERASED_WORD) else $error("erase outside its block");
    waitIdle_a: assert property (@(posedge linkClk) disable iff (!arst_n)
        (!syncMode ##1 !$past(syncMode)) |-> waitOut == !$past(waitPol))
        else $error("wait asserted outside burst");

endmodule

// ---- pkg/pfhbp_pkg.sv ----
// Constants, command codes and types of the parallel flash host bus port.
package pfhbp_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_NS = 10000;
    localparam int ERASE_TIME_NS = 100000;
    localparam logic [15:0] PROG_CYCLES =
        16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] ERASE_CYCLES =
        16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_LOCKDOWN = 8'h2f;
    localparam logic [7:0] CMD_SET_CONFIG = 8'h03;

    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_PROG_SUSP = 2;
    localparam int SR_LOCK_ERR = 1;

    localparam int RCR_ASYNC_BIT = 15;
    localparam int RCR_WAIT_POL_BIT = 10;
    localparam logic [15:0] RCR_RESET = 16'h8400;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [5:0] PIN_IDLE = 6'h3f;

    localparam logic [1:0] ID_MAKER = 2'h0;
    localparam logic [1:0] ID_DEVICE = 2'h1;
    localparam logic [1:0] ID_LOCK = 2'h2;
    localparam logic [1:0] ID_CONFIG = 2'h3;

    typedef enum logic [1:0] {
        RM_ARRAY = 2'h0,
        RM_STATUS = 2'h1,
        RM_ID = 2'h3
    } pfhbp_rmode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PROG = 3'h1,
        ST_PROG_SUSP = 3'h3,
        ST_ERASE = 3'h2,
        ST_ERASE_SUSP = 3'h6,
        ST_SUSP_PROG = 3'h7
    } pfhbp_state_t;

endpackage

// ---- dv/pfhbp_host.sv ----
// Host side model: runs the burst clock in frames and resolves the data wire.
module pfhbp_host (
    input wire logic run, // burst frame open
    input wire logic [15:0] dqOut, // device async data
    input wire logic dqOe, // device async enable
    input wire logic [15:0] syncDqOut, // device burst data
    input wire logic syncDqOe, // device burst enable
    input wire logic [15:0] hostDq, // host write data
    input wire logic hostOe, // host drives the wire
    output logic linkClk, // burst clock
    output logic [15:0] dqIn // wire level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] last = 16'h0000;
    initial linkClk = 1'b0;
    always #6 linkClk = run ? ~linkClk : 1'b0;
    // Released wire shows the inverse of its last value so a stale read cannot match.
    always @* dqIn = hostOe ? hostDq : dqOe ? dqOut : syncDqOe ? syncDqOut : ~last;
    always @(dqIn) if (hostOe || dqOe || syncDqOe) last = dqIn;
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench of the parallel flash host bus port.
module testbench import pfhbp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, arst_n = 0, run = 0, hostOe = 0, linkClk, dqOe, syncDqOe, waitOut, waitOe;
    logic chipSelN = 1, outEnN = 1, writeEnN = 1, addressValidN = 1, writeProtN = 0;
    logic resetPinN = 1;
    logic [15:0] addr = 0, hostDq = 0, dqIn, dqOut, syncDqOut, a, d, s;
    logic [1:0] dieSel;
    int errCount = 0, nCompared = 0, seed = 89606;
    pfhbp_port u_pfhbp_port (.clk, .arst_n, .linkClk, .chipSelN, .outEnN, .writeEnN,
        .addressValidN, .writeProtN, .resetPinN, .addr, .dqIn, .dqOut, .dqOe, .syncDqOut,
        .syncDqOe, .waitOut, .waitOe, .dieSel);
    pfhbp_host u_pfhbp_host (.run, .dqOut, .dqOe, .syncDqOut, .syncDqOe, .hostDq, .hostOe,
        .linkClk, .dqIn);
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] stat(input logic [7:0] f);
        return {8'h00, 8'h80 | f};
    endfunction
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        if (errCount == 0 && nCompared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [15:0] x, input logic [15:0] v);
        addr = x;
        hostDq = v;
        hostOe = 1;
        chipSelN = 0;
        writeEnN = 0;
        tick(4);
        writeEnN = 1;
        tick(1);
        hostDq = ~v;
        tick(2);
        chipSelN = 1;
        hostOe = 0;
        tick(4);
    endtask
    task automatic rd(input logic [15:0] x, output logic [15:0] v);
        addr = x;
        addressValidN = 0;
        tick(3);
        addressValidN = 1;
        tick(1);
        addr = ~x;
        chipSelN = 0;
        outEnN = 0;
        tick(5);
        v = dqIn;
        chk("die", 16'(dieSel), x[15] ? 16'h2 : 16'h1);
        chk("woe", 16'(waitOe), 16'h1);
        outEnN = 1;
        tick(3);
        chk("oe", 16'(dqOe), 16'h0);
        chk("wfl", 16'(waitOe), 16'h0);
        chipSelN = 1;
        tick(3);
    endtask
    task automatic poll(input logic [15:0] x, output logic [15:0] v);
        wr(x, CMD_READ_STATUS);
        v = 0;
        for (int i = 0; i < 800 && !v[SR_READY]; i++) rd(x, v);
    endtask
    task automatic prog(input logic [15:0] x, input logic [15:0] v, output logic [15:0] r);
        wr(x, CMD_PROGRAM);
        wr(x, v);
        poll(x, r);
    endtask
    initial begin
        #2000000;
        errCount++;
        tally_and_finish;
    end
    initial begin
        tick(16);
        arst_n = 1;
        tick(4);
        a = 16'($random(seed));
        d = 16'($random(seed)) & 16'hfffe;
        wr(a, CMD_READ_ID);
        rd(16'h0003, s);
        chk("cfg", s, RCR_RESET);
        wr(a, CMD_LOCK_SETUP);
        wr(a, CMD_CONFIRM);
        prog(a, d, s);
        chk("pst", s, stat(8'h00));
        wr(a, CMD_READ_ARRAY);
        rd(a, s);
        chk("arr", s, d);
        prog(a ^ 16'h1000, ~d, s);
        chk("lck", s & 16'h0002, 16'h0002);
        wr(a, CMD_CLEAR_STATUS);
        wr(a, CMD_ERASE);
        wr(a, CMD_CONFIRM);
        wr(a, CMD_SUSPEND);
        poll(a, s);
        chk("sus", s, stat(8'h40));
        wr(a, CMD_CONFIRM);
        poll(a, s);
        chk("ers", s, stat(8'h00));
        wr(a, CMD_READ_ARRAY);
        rd(a, s);
        chk("blk", s, ERASED_WORD);
        prog(a, d, s);
        wr(a, CMD_READ_ARRAY);
        wr(16'h0400, CMD_LOCK_SETUP);
        wr(16'h0400, CMD_SET_CONFIG);
        addr = a;
        chipSelN = 0;
        outEnN = 0;
        run = 1;
        repeat (3) @(posedge linkClk);
        #1 addressValidN = 0;
        @(posedge linkClk) #1 addressValidN = 1;
        for (int i = 0; i < 99 && !(syncDqOe === 1'b1 && waitOut === 1'b0); i++)
            @(posedge linkClk) #1;
        chk("bst", syncDqOut, d);
        chk("adq", 16'(dqOe), 16'h0);
        @(posedge linkClk) #1 chk("wt", 16'(waitOut), 16'h1);
        chipSelN = 1;
        outEnN = 1;
        run = 0;
        tick(2);
        chk("cs", 16'(syncDqOe), 16'h0);
        resetPinN = 0;
        tick(4);
        wr(a, CMD_READ_STATUS);
        resetPinN = 1;
        tick(4);
        rd(a, s);
        chk("rst", s, d);
        tally_and_finish;
    end
endmodule
